// File: rtl/gdp_top.sv
// Purpose: two 8-bit gpio ports with wishbone register access
// Assumes: pins synchronous to clk_i, 200 MHz single clock
// Notes: port1 data and direction live outside; only its pulls and gating here
`timescale 1ns/1ps
`include "gdp_cfg.svh"
module gdp_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] p1_pin_i,
  output logic [7:0] p1_pu_o,
  output logic [7:0] p1_dig_en_o,
  output logic [7:0] p1_rd_o,
  input wire logic [7:0] p2_pin_i,
  output logic [7:0] p2_out_o,
  output logic [7:0] p2_oe_n_o,
  output logic [7:0] p2_pu_o,
  input wire logic buz_i,
  input wire logic pdm_i,
  output logic irq_o
);
  // =====================================================
  // state
  gdp_pkg::gdp_regs_t rg;
  gdp_pkg::gdp_regs_t next_rg;
  gdp_pkg::gdp_bus_t bs;
  gdp_pkg::gdp_bus_t next_bs;
  gdp_pkg::gdp_pad_t pd;
  gdp_pkg::gdp_pad_t next_pd;
  logic [7:0] next_p1_pu;
  logic [7:0] next_p1_dig;
  logic [7:0] next_p1_rd;
  logic next_irq;
  logic [7:0] p1_pu_q;
  logic [7:0] p1_dig_q;
  logic [7:0] p1_rd_q;
  logic irq_q;
  // bus decode
  logic req;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wbyte;
  // trigger hits and muxed pad values
  logic [1:0] hit;
  logic [7:0] mux_out;
  logic [7:0] mux_oe_n;
  // =====================================================
  // external interrupt detectors
  gdp_edge_det u_irq0
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(p2_pin_i[0]),
    // RULE10: same coding for irq zero
    .mode_i(rg.p2_mode[1:0]),
    .hit_o(hit[0])
  );
  gdp_edge_det u_irq1
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(p2_pin_i[1]),
    .mode_i(rg.p2_mode[3:2]),
    .hit_o(hit[1])
  );
  // =====================================================
  // port2 pad mux
  gdp_pin_mux u_mux
  (
    .data_i(rg.p2_data),
    .dir_i(rg.p2_dir),
    .od_i(rg.p2_od & `GDP_OD_WMASK),
    .buz_en_i(rg.p2_mode[`GDP_MODE_BUZ]),
    .pdm_en_i(rg.p2_mode[`GDP_MODE_PDM]),
    .buz_i(buz_i),
    .pdm_i(pdm_i),
    .out_o(mux_out),
    .oe_n_o(mux_oe_n)
  );
  // =====================================================
  // bus decode: one word per register, low byte used
  always_comb
  begin
    // new request only while no ack is out, so one ack per cycle
    req = wb_cyc_i & wb_stb_i & ~bs.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    rd = req & ~wb_we_i;
    idx = wb_adr_i[7:2] == 6'h00 ? 8'h00 : {2'h0, wb_adr_i[7:2]};
    wbyte = wb_dat_i[7:0];
  end
  // register bank next state
  always_comb
  begin
    next_rg = rg;
    next_bs.ack = req;
    next_bs.dat = 32'h0000_0000;
    // read mux; unmapped reads return zero
    if (rd)
    begin
      case (idx)
        `GDP_IDX_P1_PU: next_bs.dat[7:0] = rg.p1_pu;
        `GDP_IDX_P1_INSEL: next_bs.dat[7:0] = rg.p1_insel;
        // RULE4: data readback
        `GDP_IDX_P2_DATA: next_bs.dat[7:0] = rg.p2_data;
        `GDP_IDX_P2_DIR: next_bs.dat[7:0] = rg.p2_dir;
        `GDP_IDX_P2_PU: next_bs.dat[7:0] = rg.p2_pu;
        // RULE13: unused mode bits read zero
        `GDP_IDX_P2_MODE: next_bs.dat[7:0] = rg.p2_mode & `GDP_MODE_WMASK;
        `GDP_IDX_P2_OD: next_bs.dat[7:0] = rg.p2_od & `GDP_OD_WMASK;
        `GDP_IDX_IRQ_EN: next_bs.dat[1:0] = rg.irq_en;
        `GDP_IDX_IRQ_STAT: next_bs.dat[1:0] = rg.irq_stat;
        `GDP_IDX_IRQ_MASK: next_bs.dat[1:0] = rg.irq_mask;
        // gated digital view of port1
        `GDP_IDX_P1_IN: next_bs.dat[7:0] = p1_pin_i & p1_rd_q;
        default: next_bs.dat = 32'h0000_0000;
      endcase
    end
    // writes
    if (wr)
    begin
      case (idx)
        // RULE1: port1 pull-up enables
        `GDP_IDX_P1_PU: next_rg.p1_pu = wbyte;
        // RULE2: port1 read gating and analog select
        `GDP_IDX_P1_INSEL: next_rg.p1_insel = wbyte;
        // RULE14: data latched until rewritten
        `GDP_IDX_P2_DATA: next_rg.p2_data = wbyte;
        `GDP_IDX_P2_DIR: next_rg.p2_dir = wbyte;
        `GDP_IDX_P2_PU: next_rg.p2_pu = wbyte;
        // RULE13: ignore writes to unused mode bits
        `GDP_IDX_P2_MODE: next_rg.p2_mode = wbyte & `GDP_MODE_WMASK;
        // RULE11: open-drain select bits
        `GDP_IDX_P2_OD: next_rg.p2_od = wbyte & `GDP_OD_WMASK;
        `GDP_IDX_IRQ_EN: next_rg.irq_en = wbyte[1:0];
        `GDP_IDX_IRQ_MASK: next_rg.irq_mask = wbyte[1:0];
        default: next_rg = next_rg;
      endcase
    end
    // status clears on read; a new hit in the same cycle wins
    if (rd && idx == `GDP_IDX_IRQ_STAT)
      next_rg.irq_stat = 2'h0;
    // RULE15: only enabled pins latch status
    next_rg.irq_stat = next_rg.irq_stat | (hit & rg.irq_en);
  end
  // pad and output next values
  always_comb
  begin
    next_pd.out = mux_out;
    next_pd.oe_n = mux_oe_n;
    // RULE6: port2 pull-ups
    next_pd.pu = rg.p2_pu;
    next_p1_pu = rg.p1_pu;
    // RULE3: low six bits mark digital channels
    next_p1_dig = rg.p1_insel & `GDP_P1_DIG_MASK;
    // digital read gate: bits 7:6 plain enable, 5:0 digital mode
    next_p1_rd = rg.p1_insel;
    next_irq = |(rg.irq_stat & rg.irq_mask);
  end
  // =====================================================
  // registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // RULE12: control registers clear, open drain set
      rg.p1_pu <= `GDP_RST_ZERO;
      rg.p1_insel <= `GDP_RST_ZERO;
      rg.p2_dir <= `GDP_RST_ZERO;
      rg.p2_pu <= `GDP_RST_ZERO;
      rg.p2_mode <= `GDP_RST_ZERO;
      rg.p2_od <= `GDP_RST_OD;
      rg.irq_en <= 2'h0;
      rg.irq_stat <= 2'h0;
      rg.irq_mask <= 2'h0;
      bs <= '0;
      // RULE5: direction clears to input, so no pad is driven in reset
      pd.out <= `GDP_RST_ZERO;
      pd.oe_n <= `GDP_RST_OE_N;
      pd.pu <= `GDP_RST_ZERO;
      p1_pu_q <= `GDP_RST_ZERO;
      p1_dig_q <= `GDP_RST_ZERO;
      p1_rd_q <= `GDP_RST_ZERO;
      irq_q <= 1'b0;
    end
    else
    begin
      rg.p1_pu <= next_rg.p1_pu;
      rg.p1_insel <= next_rg.p1_insel;
      rg.p2_dir <= next_rg.p2_dir;
      rg.p2_pu <= next_rg.p2_pu;
      rg.p2_mode <= next_rg.p2_mode;
      rg.p2_od <= next_rg.p2_od;
      rg.irq_en <= next_rg.irq_en;
      rg.irq_stat <= next_rg.irq_stat;
      rg.irq_mask <= next_rg.irq_mask;
      bs <= next_bs;
      pd <= next_pd;
      p1_pu_q <= next_p1_pu;
      p1_dig_q <= next_p1_dig;
      p1_rd_q <= next_p1_rd;
      irq_q <= next_irq;
    end
  end
  // data register has no reset, power-on value is unknown
  always_ff @(posedge clk_i)
  begin
    rg.p2_data <= next_rg.p2_data;
  end
  // =====================================================
  // outputs straight from flops
  assign wb_ack_o = bs.ack;
  assign wb_dat_o = bs.dat;
  assign p1_pu_o = p1_pu_q;
  assign p1_dig_en_o = p1_dig_q;
  assign p1_rd_o = p1_rd_q;
  assign p2_out_o = pd.out;
  assign p2_oe_n_o = pd.oe_n;
  assign p2_pu_o = pd.pu;
  assign irq_o = irq_q;
endmodule

// File: rtl/gdp_cfg.svh
// Purpose: constants for the dual gpio port control block
// Assumes: classic wishbone, 32-bit data, byte addresses = 4 x register index
// Notes: every offset, mode enable bit and 8-bit register reset value lives here; trigger field positions are in the top module
// Functional notes
// RULE1: port1 pull-up bit connects pin pull-up
// RULE2: input-select bits 7:6 gate digital reads
// RULE3: input-select bits 5:0 pick analog/digital
// RULE4: port2 data readable writable, unknown reset
// RULE5: port2 direction bit: 0 input, 1 output
// RULE6: port2 pull-up bit connects pin pull-up
// RULE7: buzzer enable routes buzzer to pin seven
// RULE8: pulse-density enable routes to pin two
// RULE9: irq one trigger: fall, rise, change
// RULE10: irq zero trigger uses same encoding
// RULE11: open-drain bits pins four, three, reset set
// RULE12: control registers clear at reset
// RULE13: mode bits six, five read zero
// RULE14: data write held in output flop
// RULE15: external irqs need their enable bits
// RULE16: open-drain drives low or releases line
`ifndef GDP_CFG_SVH
`define GDP_CFG_SVH
// =====================================================
// register indices (byte address is four times these)
`define GDP_IDX_P1_PU 8'h22
`define GDP_IDX_P1_INSEL 8'h23
`define GDP_IDX_P2_DATA 8'h24
`define GDP_IDX_P2_DIR 8'h25
`define GDP_IDX_P2_PU 8'h26
`define GDP_IDX_P2_MODE 8'h27
`define GDP_IDX_P2_OD 8'h37
`define GDP_IDX_IRQ_EN 8'h38
`define GDP_IDX_IRQ_STAT 8'h39
`define GDP_IDX_IRQ_MASK 8'h3a
`define GDP_IDX_P1_IN 8'h3b
// =====================================================
// field positions and masks
`define GDP_MODE_BUZ 7
`define GDP_MODE_PDM 4
`define GDP_MODE_WMASK 8'h9f
`define GDP_OD_WMASK 8'h18
`define GDP_P1_DIG_MASK 8'h3f
// =====================================================
// reset values
`define GDP_RST_ZERO 8'h00
`define GDP_RST_OD 8'h18
// pads released while in reset, direction clears to input
`define GDP_RST_OE_N 8'hff
// =====================================================
// trigger codes
`define GDP_TRIG_FALL 2'h0
`define GDP_TRIG_RISE 2'h1
`endif

// File: rtl/gdp_pkg.sv
// Purpose: types for the dual gpio port control block
// Assumes: 8-bit ports
// Notes: constants live in gdp_cfg.svh
package gdp_pkg;
  // =====================================================
  // register bank
  typedef struct packed {
    logic [7:0] p1_pu;
    logic [7:0] p1_insel;
    logic [7:0] p2_data;
    logic [7:0] p2_dir;
    logic [7:0] p2_pu;
    logic [7:0] p2_mode;
    logic [7:0] p2_od;
    logic [1:0] irq_en;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
  } gdp_regs_t;
  // pad control towards one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pu;
  } gdp_pad_t;
  // edge detector state
  typedef struct packed {
    logic prev;
    logic prim;
  } gdp_edge_t;
  // bus slave state
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gdp_bus_t;
endpackage

// File: rtl/gdp_edge_det.sv
// Purpose: trigger detector for one external interrupt pin
// Assumes: pin already synchronous to clk_i
// Notes: first sample after reset never fires
`timescale 1ns/1ps
`include "gdp_cfg.svh"
module gdp_edge_det
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic [1:0] mode_i,
  output logic hit_o
);
  // =====================================================
  // state
  gdp_pkg::gdp_edge_t st;
  gdp_pkg::gdp_edge_t next_st;
  logic fall;
  logic rise;
  // edge decode; primed flag blocks a bogus edge from reset value
  always_comb
  begin
    next_st.prev = pin_i;
    next_st.prim = 1'b1;
    fall = st.prim & st.prev & ~pin_i;
    rise = st.prim & ~st.prev & pin_i;
    // RULE9: trigger mode decode
    case (mode_i)
      `GDP_TRIG_FALL: hit_o = fall;
      `GDP_TRIG_RISE: hit_o = rise;
      default: hit_o = fall | rise;
    endcase
  end
  // register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// File: rtl/gdp_pin_mux.sv
// Purpose: port2 output mux: alternates, direction, open drain
// Assumes: buzzer and pulse-density signals come from outside
// Notes: oe_n low means the pad is driven
`timescale 1ns/1ps
`include "gdp_cfg.svh"
module gdp_pin_mux
(
  input wire logic [7:0] data_i,
  input wire logic [7:0] dir_i,
  input wire logic [7:0] od_i,
  input wire logic buz_en_i,
  input wire logic pdm_en_i,
  input wire logic buz_i,
  input wire logic pdm_i,
  output logic [7:0] out_o,
  output logic [7:0] oe_n_o
);
  logic [7:0] val;
  logic [7:0] drv;
  // per-pin selection
  always_comb
  begin
    val = data_i;
    drv = dir_i;
    // RULE7: buzzer takes pin seven
    if (buz_en_i)
    begin
      val[7] = buz_i;
      drv[7] = 1'b1;
    end
    // RULE8: pulse density takes pin two
    if (pdm_en_i)
    begin
      val[2] = pdm_i;
      drv[2] = 1'b1;
    end
  end
  // open drain handling per pin
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      // RULE16: drive low, release on one
      assign out_o[g] = od_i[g] ? 1'b0 : val[g];
      // RULE5: direction enables the driver
      assign oe_n_o[g] = ~(drv[g] & (~od_i[g] | ~val[g]));
    end
  endgenerate
endmodule

// File: testbench/gdp_pin_model.sv
// Purpose: far-side devices and pulls on the port2 pins
// Assumes: oe_n low means the design drives the pad
// Notes: a floating unpulled pin shows the inverse of the pad value
`timescale 1ns/1ps
module gdp_pin_model
(
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  // =====
  // wire level: design, then device, then pull, else junk
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_o[i] = !oe_n_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] : pu_i[i] | ~out_i[i];
  end
endmodule

// File: testbench/gdp_top_asserts.sv
// Purpose: port-level checks of gdp_top
// Assumes: ack one cycle after a taken request, pads one cycle later
// Notes: bound below the module
`timescale 1ns/1ps
module gdp_top_asserts
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] p1_pin_i,
  input wire logic [7:0] p1_pu_o,
  input wire logic [7:0] p1_dig_en_o,
  input wire logic [7:0] p1_rd_o,
  input wire logic [7:0] p2_pin_i,
  input wire logic [7:0] p2_out_o,
  input wire logic [7:0] p2_oe_n_o,
  input wire logic [7:0] p2_pu_o,
  input wire logic buz_i,
  input wire logic pdm_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // =====
  // taken requests
  logic req;
  logic wr;
  logic [5:0] ix;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign ix = wb_adr_i[7:2];
  a_ack_one_cycle: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_p1_pull_follow: assert property (wr && ix == 6'h22 |=> ##1 p1_pu_o == $past(wb_dat_i[7:0], 2))
    else $error("port1 pulls wrong");
  a_insel_follow: assert property (wr && ix == 6'h23 |=> ##1 p1_rd_o == $past(wb_dat_i[7:0], 2)
    && p1_dig_en_o == ($past(wb_dat_i[7:0], 2) & 8'h3f))
    else $error("input select wrong");
  a_p2_pull_follow: assert property (wr && ix == 6'h26 |=> ##1 p2_pu_o == $past(wb_dat_i[7:0], 2))
    else $error("port2 pulls wrong");
  a_dir_drive: assert property (wr && ix == 6'h25 |=> ##1 p2_oe_n_o[1:0] == ~$past(wb_dat_i[1:0], 2))
    else $error("direction not on pads");
  a_mode_unused_zero: assert property (req && !wb_we_i && ix == 6'h27 |=> wb_dat_o[31:5] == 27'h0 ||
    wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:5] == 2'h0)
    else $error("mode unused bits not zero");
  a_unmapped_zero: assert property (req && !wb_we_i && ix == 6'h10 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_clears: assert property ($fell(rst_i) |-> p1_pu_o == 8'h0 && p2_pu_o == 8'h0
    && p1_rd_o == 8'h0 && p2_oe_n_o == 8'hff && !wb_ack_o && !irq_o)
    else $error("outputs not clear after reset");
  // main scenarios reached
  c_mode_write: cover property (wr && ix == 6'h27);
  c_irq: cover property (irq_o);
  c_od_release: cover property ($rose(p2_oe_n_o[3]));
endmodule
bind gdp_top gdp_top_asserts gdp_top_asserts_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .p1_pin_i, .p1_pu_o,
  .p1_dig_en_o, .p1_rd_o, .p2_pin_i, .p2_out_o, .p2_oe_n_o, .p2_pu_o, .buz_i, .pdm_i, .irq_o);

// File: testbench/gdp_top_tb.sv
// Purpose: self-checking bench for gdp_top
// Assumes: classic wishbone, one byte per register word
// Notes: random values from a fixed seed, corners first
`timescale 1ns/1ps
module gdp_top_tb;
  // =====
  // design ports and bench state
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] p1_pin_i = 8'h0;
  logic [7:0] p1_pu_o;
  logic [7:0] p1_dig_en_o;
  logic [7:0] p1_rd_o;
  logic [7:0] p2_pin_i;
  logic [7:0] p2_out_o;
  logic [7:0] p2_oe_n_o;
  logic [7:0] p2_pu_o;
  logic buz_i = 1'h0;
  logic pdm_i = 1'h0;
  logic irq_o;
  logic [7:0] ext_en = 8'h0; // pins the far side drives
  logic [7:0] ext = 8'h0;
  logic [31:0] got; // last read data
  logic [7:0] mr [7]; // bench copy of the registers
  logic [7:0] ix [7] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h37};
  logic [7:0] wm [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h9f, 8'h18};
  integer seed = 32'h9f92c8b9;
  int fails = 0;
  int total_checks = 0;
  wire [7:0] p2_drv = p2_out_o & ~p2_oe_n_o;
  always #2.5 clk_i = ~clk_i;
  gdp_top gdp_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .p1_pin_i, .p1_pu_o, .p1_dig_en_o, .p1_rd_o, .p2_pin_i,
    .p2_out_o, .p2_oe_n_o, .p2_pu_o, .buz_i, .pdm_i, .irq_o);
  gdp_pin_model gdp_pin_model_inst (.out_i(p2_out_o), .oe_n_i(p2_oe_n_o), .pu_i(p2_pu_o),
    .ext_en_i(ext_en), .ext_i(ext), .pin_o(p2_pin_i));
  // =====
  // helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one classic cycle; holds until ack, then releases for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a << 2;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    got = wb_dat_o;
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 8'h0);
  endtask
  // expected driven value and oe_n of port2 from the bench copy
  function automatic logic [15:0] pad(input logic b, input logic p);
    logic [7:0] v;
    logic [7:0] e;
    v = mr[2];
    if (mr[5][7]) v[7] = b;
    if (mr[5][4]) v[2] = p;
    e = mr[3] | {mr[5][7], 4'h0, mr[5][4], 2'h0};
    e = e & ~(mr[6] & v);
    return {v & e, ~e};
  endfunction
  // trigger code c, old level a, new level is its inverse
  function automatic logic hit(input logic [1:0] c, input logic a);
    return c[1] ? 1'h1 : (c[0] ? !a : a);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog far beyond the expected run of about 1550 cycles
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end
  // =====
  // main sequence
  initial
  begin
    logic [7:0] v;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int k = 0; k < 7; k++)
    begin
      rd(ix[k]);
      if (k != 2)
        chk("reset value", k == 6 ? 32'h18 : 32'h0, got);
    end
    $display("test reset done");
    for (int i = 0; i < 30; i++)
    begin
      buz_i <= 1'($random(seed));
      pdm_i <= 1'($random(seed));
      p1_pin_i <= 8'($random(seed));
      for (int k = 0; k < 7; k++)
      begin
        v = i == 0 ? 8'hff : i == 1 ? 8'h0 : 8'($random(seed));
        wr(ix[k], v);
        rd(ix[k]);
        mr[k] = v & wm[k];
        chk("readback", {24'h0, mr[k]}, got);
      end
      chk("p1 pads", {8'h0, mr[0], mr[1], 2'h0, mr[1][5:0]}, {8'h0, p1_pu_o, p1_rd_o, p1_dig_en_o});
      rd(8'h3b);
      chk("p1 gated", {24'h0, p1_pin_i & mr[1]}, got);
      chk("p2 pulls", {24'h0, mr[4]}, {24'h0, p2_pu_o});
      chk("p2 pads", {16'h0, pad(buz_i, pdm_i)}, {16'h0, p2_drv, p2_oe_n_o});
    end
    $display("test random done");
    wr(8'h10, 8'hff);
    rd(8'h10);
    chk("unmapped", 32'h0, got);
    wb_sel_i <= 4'he;
    wr(8'h22, ~mr[0]);
    wb_sel_i <= 4'h1;
    rd(8'h22);
    chk("sel0 low", {24'h0, mr[0]}, got);
    $display("test refusal done");
    ext_en <= 8'h03;
    wr(8'h25, 8'h0);
    wr(8'h38, 8'h3);
    wr(8'h3a, 8'h3);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h27, {4'h0, c[2:1], c[2:1]});
      ext <= {8{c[0]}};
      repeat (4) @(posedge clk_i);
      rd(8'h39);
      ext <= {8{~c[0]}};
      repeat (4) @(posedge clk_i);
      chk("irq level", {31'h0, hit(c[2:1], c[0])}, {31'h0, irq_o});
      rd(8'h39);
      chk("irq status", {30'h0, {2{hit(c[2:1], c[0])}}}, got);
    end
    wr(8'h3a, 8'h0);
    ext <= 8'hff;
    repeat (4) @(posedge clk_i);
    chk("masked irq", 32'h0, {31'h0, irq_o});
    rd(8'h39);
    chk("masked status", 32'h3, got);
    wr(8'h38, 8'h0);
    ext <= 8'h0;
    repeat (4) @(posedge clk_i);
    rd(8'h39);
    chk("disabled status", 32'h0, got);
    $display("test irq done");
    stop_test();
  end
endmodule
